// ### hw/fsc_core.sv
// fan speed control core: mode handling, tach counting, alarms, gp pins
`timescale 1ns/100ps
`default_nettype none
module fsc_core
  import fsc_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fsc_ctrl_t ctrl,
  input wire logic alarm_clear,
  input wire logic [N_TACH-1:0] tach_in,
  input wire logic full_on_n,
  input wire logic [N_GP-1:0] gp_out_level,
  output logic [7:0] drive_level,
  output logic [7:0] drive_readback,
  output logic [7:0] tach_count [N_TACH],
  output logic [4:0] alarm_status,
  output logic alert_n,
  output logic [N_GP-1:0] gp_pin_oe
);
  logic [N_TACH-1:0] tach_s1, tach_s2, tach_d;
  logic full_s1, full_s2;
  logic [31:0] tick_cnt;
  logic slot_end, slot_odd;
  logic [8:0] acc [N_TACH];
  logic [N_TACH-1:0] ovf_hit;
  logic [7:0] loop_drive;
  logic [7:0] next_drive;
  logic [2:0] pre_cnt;
  logic [4:0] next_alarm;
  logic [N_TACH-1:0] tach_rise;
  logic [8:0] acc_sum [N_TACH];
  logic [2:0] prescale_q;
  logic [4:0] alarm_en_q;
  fsc_state_t state;

  // period in cycles: base doubled by kcount
  function automatic logic [31:0] period_cycles(input logic [1:0] k);
    period_cycles = 32'(BASE_CYCLES) << k;
  endfunction

  // two-flop synchronisers for pins from outside
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // tach lines idle high; resetting low would count a false edge
      tach_s1 <= '1;
      tach_s2 <= '1;
      tach_d <= '1;
      full_s1 <= 1'b1;
      full_s2 <= 1'b1;
    end else begin
      tach_s1 <= tach_in;
      tach_s2 <= tach_s1;
      tach_d <= tach_s2;
      full_s1 <= full_on_n;
      full_s2 <= full_s1;
    end
  end

  // count slot timer; slots alternate between counting and idle
  assign slot_end = (tick_cnt >= period_cycles(ctrl.kcount) - 32'h1);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      slot_odd <= 1'b0;
    end else if (slot_end) begin
      tick_cnt <= '0;
      slot_odd <= ~slot_odd;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // per-input counting; result latched only at end of a counting slot
  for (genvar i = 0; i < N_TACH; i++) begin : g_tach
    // an edge in the closing cycle still belongs to the window just ending
    assign tach_rise[i] = tach_s2[i] && !tach_d[i];
    assign acc_sum[i] = acc[i] + {8'h00, tach_rise[i]};
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        acc[i] <= '0;
        tach_count[i] <= '0;
      end else if (slot_end) begin
        acc[i] <= '0;
        if (!slot_odd) begin
          tach_count[i] <= acc_sum[i][8] ? TACH_MAX : acc_sum[i][7:0];
        end
      end else if (!slot_odd && tach_rise[i] && !acc[i][8]) begin
        acc[i] <= acc_sum[i];
      end
    end
    assign ovf_hit[i] = slot_end && !slot_odd && acc_sum[i][8];
  end

  // registered divider and enables: reset loads PRESCALE_RST and ALARM_EN_RST
  // whatever the host lines show while reset is applied
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prescale_q <= PRESCALE_RST;
      alarm_en_q <= ALARM_EN_RST;
    end else begin
      prescale_q <= ctrl.prescale;
      alarm_en_q <= ctrl.alarm_en;
    end
  end

  // mode state from config bits 5:4, override wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= FSC_ST_FULL;
    end else if (!full_s2) begin
      state <= FSC_ST_FULL;
    end else begin
      unique case (ctrl.config_reg[CFG_MODE_LO +: 2])
        MODE_FULL_ON: state <= FSC_ST_FULL;
        MODE_FULL_OFF: state <= FSC_ST_OFF;
        default: state <= FSC_ST_REG;
      endcase
    end
  end

  // closed loop: step drive once per prescaled count result from input zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loop_drive <= DRIVE_FULL;
      pre_cnt <= '0;
    end else if (slot_end && !slot_odd) begin
      pre_cnt <= pre_cnt + 3'h1;
      if ((pre_cnt & ((3'h1 << prescale_q) - 3'h1)) == 3'h0) begin
        // feedback from input zero only; ties drive to its own fan
        if (tach_count[0] < ctrl.speed_target && loop_drive != DRIVE_FULL) begin
          loop_drive <= loop_drive + 8'h1;
        end else if (tach_count[0] > ctrl.speed_target && loop_drive != DRIVE_OFF) begin
          loop_drive <= loop_drive - 8'h1;
        end
      end
    end
  end

  // drive selection
  always_comb begin
    next_drive = DRIVE_FULL;
    unique case (state)
      FSC_ST_FULL: next_drive = DRIVE_FULL;
      FSC_ST_OFF: next_drive = DRIVE_OFF;
      FSC_ST_REG: begin
        if (ctrl.config_reg[CFG_MODE_LO +: 2] == MODE_CLOSED) begin
          next_drive = loop_drive;
        end else begin
          next_drive = ctrl.drive_wr;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_level <= DRIVE_FULL;
      drive_readback <= DRIVE_OFF;
    end else begin
      drive_level <= next_drive;
      // readback shows loop output in closed loop, else software value
      drive_readback <= (ctrl.config_reg[CFG_MODE_LO +: 2] == MODE_CLOSED) ?
                        loop_drive : ctrl.drive_wr;
    end
  end

  // sticky alarms; a new event beats a clear in the same cycle
  always_comb begin
    next_alarm = alarm_clear ? 5'h00 : alarm_status;
    next_alarm[AL_MAX] = next_alarm[AL_MAX] | (state == FSC_ST_REG &&
                         loop_drive == DRIVE_FULL && alarm_en_q[AL_MAX]);
    next_alarm[AL_MIN] = next_alarm[AL_MIN] | (state == FSC_ST_REG &&
                         loop_drive == DRIVE_OFF && alarm_en_q[AL_MIN]);
    next_alarm[AL_TACH] = next_alarm[AL_TACH] | (|ovf_hit && alarm_en_q[AL_TACH]);
    next_alarm[AL_GP1] = next_alarm[AL_GP1] | (!full_s2 && alarm_en_q[AL_GP1]);
    next_alarm[AL_GP2] = next_alarm[AL_GP2] | (!gp_out_level[2] && alarm_en_q[AL_GP2]);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_status <= ALARM_EN_RST;
      alert_n <= 1'b1;
    end else begin
      alarm_status <= next_alarm;
      alert_n <= ~|next_alarm;
    end
  end

  // gp pins open drain: enable low pulls the pin low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gp_pin_oe <= '1;
    end else begin
      gp_pin_oe <= gp_out_level;
    end
  end

  slot_alternate_a: assert property (@(posedge mclk) disable iff (rst)
    slot_end |=> slot_odd != $past(slot_odd)) else $error("slot did not alternate");
  override_full_a: assert property (@(posedge mclk) disable iff (rst)
    !full_s2 |=> ##1 drive_level == DRIVE_FULL) else $error("override not full");
  closed_ignore_a: assert property (@(posedge mclk) disable iff (rst)
    state == FSC_ST_REG && ctrl.config_reg[CFG_MODE_LO +: 2] == MODE_CLOSED
    |=> drive_level == $past(loop_drive)) else $error("closed loop used sw value");
  readback_loop_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl.config_reg[CFG_MODE_LO +: 2] == MODE_CLOSED |=> drive_readback == $past(loop_drive))
    else $error("readback not loop value");
  off_mode_a: assert property (@(posedge mclk) disable iff (rst)
    full_s2 && ctrl.config_reg[CFG_MODE_LO +: 2] == MODE_FULL_OFF |=> ##1 drive_level == DRIVE_OFF)
    else $error("full off not applied");
  count_sat_a: assert property (@(posedge mclk) disable iff (rst)
    ovf_hit[0] |=> tach_count[0] == TACH_MAX) else $error("count not saturated");
  alert_gate_a: assert property (@(posedge mclk) disable iff (rst)
    alarm_status == 5'h00 |-> alert_n) else $error("alert without alarm");
  alarm_hold_a: assert property (@(posedge mclk) disable iff (rst)
    alarm_status[AL_TACH] && !alarm_clear |=> alarm_status[AL_TACH])
    else $error("alarm dropped without clear");
  gp_drive_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> gp_pin_oe == $past(gp_out_level)) else $error("gp level wrong");

  cov_closed: cover property (@(posedge mclk) state == FSC_ST_REG && !alert_n);
  cov_ovf: cover property (@(posedge mclk) ovf_hit[0]);
  cov_override: cover property (@(posedge mclk) !full_s2 ##1 state == FSC_ST_FULL);
endmodule
`default_nettype wire

// ### hw/fsc_pkg.sv
// package: constants and carrier types for the fan speed control core
package fsc_pkg;
  localparam int CLK_HZ = 25000000;
  // base count period 0.25 s, in milliseconds
  localparam int COUNT_BASE_MS = 250;
  localparam int BASE_CYC = CLK_HZ / 1000 * COUNT_BASE_MS;
  localparam logic [7:0] DRIVE_FULL = 8'hFF;
  localparam logic [7:0] DRIVE_OFF = 8'h00;
  localparam logic [7:0] TACH_MAX = 8'hFF;
  localparam logic [1:0] MODE_FULL_ON = 2'h0;
  localparam logic [1:0] MODE_FULL_OFF = 2'h1;
  localparam logic [1:0] MODE_OPEN = 2'h2;
  localparam logic [1:0] MODE_CLOSED = 2'h3;
  localparam int CFG_MODE_LO = 4;
  localparam logic [2:0] PRESCALE_RST = 3'h2; // log2 of divide-by-4
  localparam logic [1:0] KCOUNT_RST = 2'h2;   // 1 s count time
  localparam logic [4:0] ALARM_EN_RST = 5'h00;
  localparam int AL_MAX = 0;
  localparam int AL_MIN = 1;
  localparam int AL_TACH = 2;
  localparam int AL_GP1 = 3;
  localparam int AL_GP2 = 4;
  localparam int N_TACH = 4;
  localparam int N_GP = 5;

  // software-facing control bundle
  typedef struct packed {
    logic [7:0] config_reg;
    logic [7:0] drive_wr;
    logic [7:0] speed_target;
    logic [1:0] kcount;
    logic [2:0] prescale;
    logic [4:0] alarm_en;
  } fsc_ctrl_t;

  typedef enum logic [2:0] {
    FSC_ST_FULL = 3'h1,
    FSC_ST_OFF = 3'h2,
    FSC_ST_REG = 3'h4
  } fsc_state_t;
endpackage

// ### testbench/fsc_tach_model.sv
// fan tachometer pulse source for the control core bench
`timescale 1ns/100ps
`default_nettype none
module fsc_tach_model (
  input wire logic mclk,
  input wire logic [7:0] per [4],
  output logic [3:0] tach_in
);
  logic [7:0] cnt [4] = '{default: 8'h00};
  // one rising edge per period of 2 or more; period 0 leaves the pulled-up line high
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= (cnt[i] + 8'h01 >= per[i]) ? 8'h00 : cnt[i] + 8'h01;
      tach_in[i] <= (per[i] == 8'h00) || (cnt[i] < {1'b0, per[i][7:1]});
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_fsc_core.sv
// self-checking bench for the fan speed control core
`timescale 1ns/100ps
`default_nettype none
module test_fsc_core;
  import fsc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  fsc_ctrl_t ctrl = '0;
  logic alarm_clear = 1'b0;
  logic full_on_n = 1'b1;
  logic [4:0] gp_lvl = 5'h1F;
  logic [7:0] per [4] = '{default: 8'h00};
  logic [3:0] tach;
  logic [7:0] drv, rb;
  logic [7:0] cnt [4];
  logic [4:0] al, oe;
  logic alert_n;
  int errors = 0;
  int compares = 0;
  always #20 mclk = ~mclk;
  fsc_tach_model i_fans (.mclk(mclk), .per(per), .tach_in(tach));
  // short base period keeps the run small; counts scale with it
  fsc_core #(.BASE_CYCLES(160)) i_dut (.mclk(mclk), .rst(rst), .ctrl(ctrl),
    .alarm_clear(alarm_clear), .tach_in(tach), .full_on_n(full_on_n),
    .gp_out_level(gp_lvl), .drive_level(drv), .drive_readback(rb),
    .tach_count(cnt), .alarm_status(al), .alert_n(alert_n), .gp_pin_oe(oe));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // defaults seen while reset is held
  task automatic t_reset;
    chk(drv, DRIVE_FULL);
    chk(rb, DRIVE_OFF);
    chk(8'(al), 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    chk(cnt[0], 8'h00);
    chk(8'(oe), 8'h1F);
  endtask
  task automatic t_modes;
    logic [7:0] want [3] = '{DRIVE_FULL, DRIVE_OFF, 8'h08};
    for (int m = 0; m < 3; m++) begin
      ctrl.config_reg <= 8'(m << CFG_MODE_LO);
      ctrl.drive_wr <= 8'h08;
      cyc(4);
      chk(drv, want[m]);
    end
    ctrl.drive_wr <= 8'hB0;
    cyc(12500);
    chk(rb, 8'hB0);
    full_on_n <= 1'b0;
    cyc(6);
    chk(drv, DRIVE_FULL);
    full_on_n <= 1'b1;
    cyc(6);
    chk(drv, 8'hB0);
  endtask
  // gp2 low must not raise an alarm while enables are off
  task automatic t_gp;
    gp_lvl <= 5'h0A;
    cyc(3);
    chk(8'(oe), 8'h0A);
    gp_lvl <= 5'h15;
    cyc(3);
    chk(8'(oe), 8'h15);
    chk(8'(al), 8'h00);
    // enabled gp2 low and override low both latch and pull alert low
    ctrl.alarm_en <= 5'h18;
    gp_lvl <= 5'h1B;
    full_on_n <= 1'b0;
    cyc(6);
    chk(8'(oe), 8'h1B);
    chk(8'(al), 8'h18);
    chk({7'h00, alert_n}, 8'h00);
    ctrl.alarm_en <= 5'h00;
    full_on_n <= 1'b1;
    gp_lvl <= 5'h1F;
    cyc(6);
    alarm_clear <= 1'b1;
    cyc(1);
    alarm_clear <= 1'b0;
    cyc(3);
    chk(8'(al), 8'h00);
  endtask
  // windows are whole multiples of each pulse period, so counts are exact
  task automatic t_tach;
    per <= '{8'h04, 8'h05, 8'h08, 8'h0A};
    cyc(160 * 6);
    chk(cnt[0], 8'h28);
    chk(cnt[1], 8'h20);
    chk(cnt[2], 8'h14);
    chk(cnt[3], 8'h10);
    ctrl.kcount <= 2'h1;
    cyc(320 * 5);
    chk(cnt[0], 8'h50);
  endtask
  task automatic t_ovf;
    int n;
    per[0] <= 8'h02;
    ctrl.kcount <= 2'h2;
    cyc(640 * 5);
    chk(cnt[0], TACH_MAX);
    chk(8'(al), 8'h00);
    ctrl.alarm_en <= 5'h04;
    for (n = 0; n < 2000 && alert_n !== 1'b0; n++) cyc(1);
    if (n == 2000) begin
      errors++;
      test_done;
    end
    chk(8'(al), 8'h04);
    chk({7'h00, alert_n}, 8'h00);
    per[0] <= 8'h00;
    ctrl.alarm_en <= 5'h00;
    cyc(640 * 5);
    chk(8'(al), 8'h04);
    alarm_clear <= 1'b1;
    cyc(1);
    alarm_clear <= 1'b0;
    cyc(3);
    chk(8'(al), 8'h00);
    chk({7'h00, alert_n}, 8'h01);
  endtask
  // tach zero runs above target, tach one silent: loop must step down
  task automatic t_closed;
    logic [7:0] d;
    ctrl.kcount <= 2'h0;
    ctrl.prescale <= 3'h0;
    ctrl.speed_target <= 8'h01;
    per <= '{8'h04, 8'h00, 8'h00, 8'h00};
    ctrl.config_reg <= 8'h30;
    cyc(160 * 4);
    d = drv;
    ctrl.drive_wr <= 8'hC0;
    cyc(160 * 8);
    chk({7'h00, drv < d}, 8'h01);
    chk({7'h00, drv != 8'hC0}, 8'h01);
    chk({7'h00, rb === drv}, 8'h01);
  endtask
  initial begin
    cyc(3);
    t_reset;
    rst <= 1'b0;
    cyc(2);
    t_modes;
    t_gp;
    t_tach;
    t_ovf;
    t_closed;
    test_done;
  end
endmodule
`default_nettype wire
